// ==== rtl/card16_cycle_engine.sv ====
// Setup, strobe and hold sequencer for one card access.
// Assumes start is only pulsed while the phase is idle.
`default_nettype none

module card16_cycle_engine (
  input wire logic          clk_i,
  input wire logic          rst_b_i,
  card16_cycle_if.engine    cyc
);
  import card16_pkg::*;

  logic [CNT_W-1:0] cnt;

  // ----------------------------------------------------------------
  // Phase sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cyc.phase <= PH_IDLE;
      cnt       <= '0;
    end else begin
      case (cyc.phase)
        PH_IDLE: begin
          if (cyc.start) begin
            cyc.phase <= PH_SETUP;
            cnt       <= CNT_W'(SETUP_CYC - 1);
          end
        end
        PH_SETUP: begin
          if (cnt == '0) begin
            cyc.phase <= PH_STROBE;
            cnt       <= CNT_W'(STROBE_CYC - 1);
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        PH_STROBE: begin
          // The strobe never ends while the card asks for more time.
          if (cnt != '0) begin
            cnt <= cnt - 1'b1;
          end else if (!cyc.wait_active) begin
            cyc.phase <= PH_HOLD;
            cnt       <= CNT_W'(HOLD_CYC - 1);
          end
        end
        PH_HOLD: begin
          if (cnt == '0) begin
            cyc.phase <= PH_IDLE;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        default: cyc.phase <= PH_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cyc.done <= 1'b0;
    end else begin
      cyc.done <= (cyc.phase == PH_HOLD) && (cnt == '0);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  property p_wait_hold;
    (cyc.phase == PH_STROBE && cnt == '0 && cyc.wait_active)
      |=> (cyc.phase == PH_STROBE);
  endproperty
  a_wait_hold: assert property (p_wait_hold)
    else $error("Strobe ended while card wait was asserted.");

  property p_done_follows_hold;
    cyc.done |-> (cyc.phase == PH_IDLE) && ($past(cyc.phase) == PH_HOLD);
  endproperty
  a_done_follows_hold: assert property (p_done_follows_hold)
    else $error("Done pulse without a preceding hold phase.");

  c_wait_extend: cover property (
    cyc.phase == PH_STROBE && cnt == '0 && cyc.wait_active);

endmodule : card16_cycle_engine

`default_nettype wire

// ==== rtl/card16_socket_control.sv ====
// Control signalling for one 16-bit card socket: strobes, attribute
// select, byte enables, card reset, wait handling and shared status pins.
// Assumes the host side request port and all card inputs are synchronous
// to CLK_SYS_I; instantiate once per socket.
`default_nettype none

module card16_socket_control (
  input  wire logic                      CLK_SYS_I,
  input  wire logic                      RST_B_I,
  // Host request port.
  input  wire logic                      REQ_VALID_I,
  input  wire card16_pkg::access_kind_t  REQ_KIND_I,
  input  wire logic                      REQ_ATTR_I,
  input  wire logic [1:0]                REQ_BYTE_EN_I,
  input  wire logic                      REQ_TC_I,
  output logic                           REQ_READY_O,
  output logic                           DONE_O,
  // Socket configuration.
  input  wire logic                      IO_MODE_I,
  input  wire logic                      DMA_MODE_I,
  input  wire logic                      CARD_RESET_REQ_I,
  // Card control outputs, active low except CARD_RESET_O, which is active high.
  output logic                           EVEN_BYTE_ENABLE_B_O,
  output logic                           ODD_BYTE_ENABLE_B_O,
  output logic                           OE_B_O,
  output logic                           WE_B_O,
  output logic                           IO_READ_STROBE_B_O,
  output logic                           IO_WRITE_STROBE_B_O,
  output logic                           ATTR_SELECT_B_O,
  output logic                           CARD_RESET_O,
  // Card inputs.
  input  wire logic                      WAIT_B_I,
  input  wire logic                      READY_IRQ_PIN_I,
  input  wire logic                      WP_PIN_I,
  input  wire logic                      VOLTAGE_SENSE_ONE_B_I,
  input  wire logic                      VOLTAGE_SENSE_TWO_B_I,
  // Decoded status.
  output logic                           CARD_READY_O,
  output logic                           CARD_INTERRUPT_REQUEST_O,
  output logic                           WRITE_PROTECT_O,
  output logic                           SIXTEEN_BIT_PORT_INDICATION_O,
  output logic                           DMA_REQUEST_O,
  output card16_pkg::volt_class_t        VOLTAGE_CLASS_O
);
  import card16_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic volt_class_t volt_decode(input logic vs1_b,
                                              input logic vs2_b);
    volt_class_t v;
    case ({vs2_b, vs1_b})
      2'h3:    v = VOLT_5V;
      2'h2:    v = VOLT_3V3;
      2'h1:    v = VOLT_DUAL;
      default: v = VOLT_LOW;
    endcase
    return v;
  endfunction

  function automatic logic is_dma(input access_kind_t k);
    return (k == KIND_DMA_RD) || (k == KIND_DMA_WR);
  endfunction

  function automatic logic is_io(input access_kind_t k);
    return (k == KIND_IO_RD) || (k == KIND_IO_WR);
  endfunction

  card16_cycle_if cyc ();

  access_kind_t kind_q;
  logic         attr_q;
  logic [1:0]   be_q;
  logic         tc_q;
  logic         busy;
  logic         take;
  logic         active;
  logic         strobe;
  logic         next_attr_b;
  logic         next_oe_b;
  logic         next_we_b;
  logic         next_io_read_strobe_b;
  logic         next_io_write_strobe_b;

  assign take            = REQ_VALID_I && REQ_READY_O;
  assign cyc.start       = take;
  assign cyc.wait_active = !WAIT_B_I;

  card16_cycle_engine u_engine (
    .clk_i   (CLK_SYS_I),
    .rst_b_i (RST_B_I),
    .cyc     (cyc.engine)
  );

  // ----------------------------------------------------------------
  // Request capture
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      kind_q <= KIND_MEM_RD;
      attr_q <= 1'b0;
      be_q   <= 2'h0;
      tc_q   <= 1'b0;
    end else if (take) begin
      kind_q <= REQ_KIND_I;
      attr_q <= REQ_ATTR_I;
      be_q   <= REQ_BYTE_EN_I;
      tc_q   <= REQ_TC_I;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      busy <= 1'b0;
    end else if (take) begin
      busy <= 1'b1;
    end else if (cyc.done) begin
      busy <= 1'b0;
    end
  end

  // Requests are refused while the card is held in reset.
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      REQ_READY_O <= 1'b0;
      DONE_O      <= 1'b0;
    end else begin
      REQ_READY_O <= !CARD_RESET_REQ_I && !take && (!busy || cyc.done);
      DONE_O      <= cyc.done;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      CARD_RESET_O <= CARD_RESET_INIT;
    end else begin
      CARD_RESET_O <= CARD_RESET_REQ_I;
    end
  end

  // ----------------------------------------------------------------
  // Strobe and select decode
  // ----------------------------------------------------------------
  assign active = (cyc.phase != PH_IDLE);
  assign strobe = (cyc.phase == PH_STROBE);

  always_comb begin
    // Common memory never sees attribute select; I/O and DMA always do.
    next_attr_b = !(active && (attr_q || is_io(kind_q) ||
                   is_dma(kind_q)));
    next_oe_b   = !(strobe && ((kind_q == KIND_MEM_RD) ||
                   (kind_q == KIND_DMA_WR && tc_q)));
    next_we_b   = !(strobe && ((kind_q == KIND_MEM_WR) ||
                   (kind_q == KIND_DMA_RD && tc_q)));
    next_io_read_strobe_b = !(strobe && ((kind_q == KIND_IO_RD) ||
                   (kind_q == KIND_DMA_WR)));
    next_io_write_strobe_b = !(strobe && ((kind_q == KIND_IO_WR) ||
                   (kind_q == KIND_DMA_RD)));
  end

  // Pins follow the engine phase one cycle late; the setup and hold
  // phases absorb that lag on both edges of the strobe.
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      EVEN_BYTE_ENABLE_B_O <= PIN_IDLE;
      ODD_BYTE_ENABLE_B_O  <= PIN_IDLE;
      OE_B_O               <= PIN_IDLE;
      WE_B_O               <= PIN_IDLE;
      IO_READ_STROBE_B_O   <= PIN_IDLE;
      IO_WRITE_STROBE_B_O  <= PIN_IDLE;
      ATTR_SELECT_B_O      <= PIN_IDLE;
    end else begin
      EVEN_BYTE_ENABLE_B_O <= !(active && be_q[0]);
      ODD_BYTE_ENABLE_B_O  <= !(active && be_q[1]);
      OE_B_O               <= next_oe_b;
      WE_B_O               <= next_we_b;
      IO_READ_STROBE_B_O   <= next_io_read_strobe_b;
      IO_WRITE_STROBE_B_O  <= next_io_write_strobe_b;
      ATTR_SELECT_B_O      <= next_attr_b;
    end
  end

  // ----------------------------------------------------------------
  // Shared status pins
  // ----------------------------------------------------------------
  // The ready and protect pins mean different things per mode, so each
  // decoded output is forced inactive outside the mode that defines it.
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      CARD_READY_O                  <= 1'b0;
      CARD_INTERRUPT_REQUEST_O      <= 1'b0;
      WRITE_PROTECT_O               <= 1'b0;
      SIXTEEN_BIT_PORT_INDICATION_O <= 1'b0;
      DMA_REQUEST_O                 <= 1'b0;
    end else begin
      CARD_READY_O                  <= !IO_MODE_I && READY_IRQ_PIN_I;
      CARD_INTERRUPT_REQUEST_O      <= IO_MODE_I && !READY_IRQ_PIN_I;
      WRITE_PROTECT_O <= !IO_MODE_I && !DMA_MODE_I && WP_PIN_I;
      SIXTEEN_BIT_PORT_INDICATION_O <=
        IO_MODE_I && !DMA_MODE_I && !WP_PIN_I;
      DMA_REQUEST_O                 <= DMA_MODE_I && WP_PIN_I;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      VOLTAGE_CLASS_O <= VOLT_5V;
    end else begin
      VOLTAGE_CLASS_O <= volt_decode(VOLTAGE_SENSE_ONE_B_I,
                                     VOLTAGE_SENSE_TWO_B_I);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_B_I);

  property p_common_attr_high;
    (!OE_B_O || !WE_B_O) && !attr_q && !is_dma(kind_q) |-> ATTR_SELECT_B_O;
  endproperty
  a_common_attr_high: assert property (p_common_attr_high)
    else $error("Attribute select low during common memory access.");

  property p_io_attr_low;
    (!IO_READ_STROBE_B_O || !IO_WRITE_STROBE_B_O)
      |-> !ATTR_SELECT_B_O && OE_B_O == (kind_q != KIND_DMA_WR || !tc_q);
  endproperty
  a_io_attr_low: assert property (p_io_attr_low)
    else $error("I/O strobe active without attribute select.");

  property p_dma_ack;
    (busy && is_dma(kind_q) && cyc.phase == PH_STROBE)
      |=> !ATTR_SELECT_B_O && (IO_READ_STROBE_B_O != IO_WRITE_STROBE_B_O);
  endproperty
  a_dma_ack: assert property (p_dma_ack)
    else $error("DMA strobe without acknowledge or with wrong strobe.");

  property p_card_reset;
    CARD_RESET_REQ_I |=> CARD_RESET_O && !REQ_READY_O;
  endproperty
  a_card_reset: assert property (p_card_reset)
    else $error("Card reset request did not reach the card.");

  property p_mem_write;
    (!WE_B_O && !is_dma(kind_q)) |-> kind_q == KIND_MEM_WR && OE_B_O;
  endproperty
  a_mem_write: assert property (p_mem_write)
    else $error("Write strobe active outside a memory write.");

  property p_tc_dma_read;
    (!IO_WRITE_STROBE_B_O && kind_q == KIND_DMA_RD) |-> WE_B_O == !tc_q;
  endproperty
  a_tc_dma_read: assert property (p_tc_dma_read)
    else $error("Terminal count on write strobe is wrong.");

  property p_tc_dma_write;
    (!IO_READ_STROBE_B_O && kind_q == KIND_DMA_WR) |-> OE_B_O == !tc_q;
  endproperty
  a_tc_dma_write: assert property (p_tc_dma_write)
    else $error("Terminal count on output enable is wrong.");

  property p_volt_low;
    (!VOLTAGE_SENSE_ONE_B_I && !VOLTAGE_SENSE_TWO_B_I)
      |=> VOLTAGE_CLASS_O == VOLT_LOW;
  endproperty
  a_volt_low: assert property (p_volt_low)
    else $error("Voltage class wrong with both sense lines low.");

  property p_byte_lanes;
    (!OE_B_O || !WE_B_O || !IO_READ_STROBE_B_O || !IO_WRITE_STROBE_B_O)
      |-> EVEN_BYTE_ENABLE_B_O == !be_q[0] && ODD_BYTE_ENABLE_B_O == !be_q[1];
  endproperty
  a_byte_lanes: assert property (p_byte_lanes)
    else $error("Byte enables do not match the requested lanes.");

  property p_mode_split;
    !IO_MODE_I |=> !CARD_INTERRUPT_REQUEST_O && !SIXTEEN_BIT_PORT_INDICATION_O;
  endproperty
  a_mode_split: assert property (p_mode_split)
    else $error("I/O status decoded while in memory mode.");

  c_mem_write: cover property (!WE_B_O && kind_q == KIND_MEM_WR);
  c_dma_tc: cover property (!WE_B_O && kind_q == KIND_DMA_RD);
  c_io_read: cover property (!IO_READ_STROBE_B_O && kind_q == KIND_IO_RD);

endmodule : card16_socket_control

`default_nettype wire

// ==== shared/card16_cycle_if.sv ====
// Handshake between the socket controller and its cycle timing engine.
// Assumes both ends sit on the same system clock.
`default_nettype none

interface card16_cycle_if;
  import card16_pkg::*;

  logic         start;
  logic         wait_active;
  cycle_phase_t phase;
  logic         done;

  modport engine (input start, input wait_active,
                  output phase, output done);
  modport ctrl   (output start, output wait_active,
                  input phase, input done);
endinterface : card16_cycle_if

`default_nettype wire

// ==== shared/card16_pkg.sv ====
// Constants, types and timing for one 16-bit card socket controller.
// Assumes a single 125 MHz system clock; card pins are synchronous to it.
`default_nettype none

package card16_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int SETUP_NS      = 30;
  localparam int STROBE_NS     = 150;
  localparam int HOLD_NS       = 20;
  localparam int SETUP_CYC  = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC   = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W      = 8;

  // ----------------------------------------------------------------
  // Pin levels and codes
  // ----------------------------------------------------------------
  localparam logic PIN_IDLE        = 1'h1;
  localparam logic CARD_RESET_INIT = 1'h1;

  typedef enum logic [1:0] {
    VOLT_5V, VOLT_3V3, VOLT_LOW, VOLT_DUAL
  } volt_class_t;

  // Four-state base so the kind can travel on a wire port.
  typedef enum logic [2:0] {
    KIND_MEM_RD, KIND_MEM_WR, KIND_IO_RD, KIND_IO_WR,
    KIND_DMA_RD, KIND_DMA_WR
  } access_kind_t;

  typedef enum {
    PH_IDLE, PH_SETUP, PH_STROBE, PH_HOLD
  } cycle_phase_t;

endpackage : card16_pkg

`default_nettype wire

// ==== verification/card16_card_model.sv ====
// Behavioural 16-bit card facing one socket controller.
// Assumes all pins run on the controller's system clock.
`default_nettype none

module card16_card_model (
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic [3:0] strobe_b_i,
  input  wire logic       io_mode_i,
  input  wire logic       dma_mode_i,
  input  wire logic       busy_i,
  input  wire logic       irq_i,
  input  wire logic       protect_i,
  input  wire logic       port16_i,
  input  wire logic       dma_req_i,
  input  wire logic [1:0] volt_code_i,
  input  wire logic [7:0] wait_extra_i,
  output logic            ready_irq_pin_o,
  output logic            wp_pin_o,
  output logic            vs1_b_o,
  output logic            vs2_b_o,
  output logic            wait_b_o
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [7:0] strobe_cnt;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      strobe_cnt <= 8'h00;
    end else if (strobe_b_i != 4'hF) begin
      strobe_cnt <= strobe_cnt + 8'h01;
    end else begin
      strobe_cnt <= 8'h00;
    end
  end

  // Wait always drops mid-strobe, so an early wait must be ignored; it
  // reaches the last strobe cycle only when extra cycles are asked for.
  assign wait_b_o = !(strobe_cnt >= 8'h0A &&
                      strobe_cnt < 8'h11 + wait_extra_i);
  assign ready_irq_pin_o = io_mode_i ? !irq_i : !busy_i;
  assign wp_pin_o = dma_mode_i ? dma_req_i :
                    (io_mode_i ? !port16_i : protect_i);
  assign {vs2_b_o, vs1_b_o} = volt_code_i;
endmodule // card16_card_model

`default_nettype wire

// ==== verification/card16_socket_control_tb.sv ====
// Self-checking bench for one socket controller with a card model.
// Assumes the package and interface files are compiled first.
`default_nettype none

module card16_socket_control_tb;
  import card16_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk = 1'b0, rst_b = 1'b0, req_valid = 1'b0, req_attr = 1'b0;
  logic req_tc = 1'b0, io_mode = 1'b0, dma_mode = 1'b0, reset_req = 1'b0;
  logic busy = 1'b0, irq = 1'b0, protect = 1'b0, port16 = 1'b0;
  logic dma_req = 1'b0;
  logic [1:0] req_be = 2'h3, volt_code = 2'h3;
  logic [7:0] wait_extra = 8'h00;
  access_kind_t req_kind = KIND_MEM_RD;
  logic oe_b, we_b, io_read_strobe_b, io_write_strobe_b, attr_b, even_b, odd_b, card_reset;
  logic wait_b, ready_pin, wp_pin, vs1_b, vs2_b, req_ready, done;
  logic card_ready, card_irq, wprot, port16_ind, dma_request;
  volt_class_t volt_class;
  int miscompares = 0, samples_checked = 0, cycles = 0;
  int seed = 32'h701685A3;

  initial begin
    forever #4 clk = ~clk;
  end

  card16_socket_control dut (
    .CLK_SYS_I(clk), .RST_B_I(rst_b), .REQ_VALID_I(req_valid),
    .REQ_KIND_I(req_kind), .REQ_ATTR_I(req_attr), .REQ_BYTE_EN_I(req_be),
    .REQ_TC_I(req_tc), .REQ_READY_O(req_ready), .DONE_O(done),
    .IO_MODE_I(io_mode), .DMA_MODE_I(dma_mode),
    .CARD_RESET_REQ_I(reset_req), .EVEN_BYTE_ENABLE_B_O(even_b),
    .ODD_BYTE_ENABLE_B_O(odd_b), .OE_B_O(oe_b), .WE_B_O(we_b),
    .IO_READ_STROBE_B_O(io_read_strobe_b), .IO_WRITE_STROBE_B_O(io_write_strobe_b),
    .ATTR_SELECT_B_O(attr_b), .CARD_RESET_O(card_reset),
    .WAIT_B_I(wait_b), .READY_IRQ_PIN_I(ready_pin), .WP_PIN_I(wp_pin),
    .VOLTAGE_SENSE_ONE_B_I(vs1_b), .VOLTAGE_SENSE_TWO_B_I(vs2_b),
    .CARD_READY_O(card_ready), .CARD_INTERRUPT_REQUEST_O(card_irq),
    .WRITE_PROTECT_O(wprot), .SIXTEEN_BIT_PORT_INDICATION_O(port16_ind),
    .DMA_REQUEST_O(dma_request), .VOLTAGE_CLASS_O(volt_class));

  card16_card_model card (
    .clk_i(clk), .rst_b_i(rst_b), .strobe_b_i({oe_b, we_b, io_read_strobe_b, io_write_strobe_b}),
    .io_mode_i(io_mode), .dma_mode_i(dma_mode), .busy_i(busy),
    .irq_i(irq), .protect_i(protect), .port16_i(port16),
    .dma_req_i(dma_req), .volt_code_i(volt_code),
    .wait_extra_i(wait_extra), .ready_irq_pin_o(ready_pin),
    .wp_pin_o(wp_pin), .vs1_b_o(vs1_b), .vs2_b_o(vs2_b),
    .wait_b_o(wait_b));

  // ----------------------------------------------------------------
  // Expectations and checking
  // ----------------------------------------------------------------
  function automatic logic [3:0] exp_strobe(access_kind_t k, logic tc);
    case (k)
      KIND_MEM_RD: exp_strobe = 4'h7;
      KIND_MEM_WR: exp_strobe = 4'hB;
      KIND_IO_RD:  exp_strobe = 4'hD;
      KIND_IO_WR:  exp_strobe = 4'hE;
      KIND_DMA_RD: exp_strobe = tc ? 4'hA : 4'hE;
      default:     exp_strobe = tc ? 4'h5 : 4'hD;
    endcase
  endfunction

  function automatic volt_class_t exp_volt(logic [1:0] code);
    case (code)
      2'h3:    exp_volt = VOLT_5V;
      2'h2:    exp_volt = VOLT_3V3;
      2'h1:    exp_volt = VOLT_DUAL;
      default: exp_volt = VOLT_LOW;
    endcase
  endfunction

  task automatic check(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic access(input access_kind_t k, input logic attr,
                        input logic [1:0] be, input logic tc, input int extra);
    int n;
    logic mem;
    mem = (k == KIND_MEM_RD || k == KIND_MEM_WR);
    io_mode = !mem;
    dma_mode = (k == KIND_DMA_RD || k == KIND_DMA_WR);
    wait_extra = extra[7:0];
    n = 0;
    while (req_ready !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    check({7'h00, req_ready}, 8'h01, "ready before request");
    req_valid = 1'b1;
    req_kind = k;
    req_attr = attr;
    req_be = be;
    req_tc = tc;
    tick(1);
    req_valid = 1'b0;
    tick(15);
    check({4'h0, oe_b, we_b, io_read_strobe_b, io_write_strobe_b}, {4'h0, exp_strobe(k, tc)},
          "strobes");
    check({7'h00, attr_b}, {7'h00, mem && !attr}, "attr select");
    check({6'h00, odd_b, even_b}, {6'h00, ~be}, "byte enables");
    check({7'h00, req_ready}, 8'h00, "ready while busy");
    n = 15;
    while (done !== 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    check(8'(n), 8'(SETUP_CYC + STROBE_CYC + HOLD_CYC + 1 + extra),
          "done time");
    check({1'b0, oe_b, we_b, io_read_strobe_b, io_write_strobe_b, attr_b, odd_b, even_b},
          8'h7F, "idle pins");
  endtask

  task automatic status_round;
    io_mode = $random(seed);
    dma_mode = $random(seed);
    busy = $random(seed);
    irq = $random(seed);
    protect = $random(seed);
    port16 = $random(seed);
    dma_req = $random(seed);
    volt_code = $random(seed);
    tick(2);
    check({7'h00, card_ready}, {7'h00, !io_mode && !busy}, "ready");
    check({7'h00, card_irq}, {7'h00, io_mode && irq}, "irq");
    check({7'h00, wprot}, {7'h00, !io_mode && !dma_mode && protect},
          "protect");
    check({7'h00, port16_ind}, {7'h00, io_mode && !dma_mode && port16},
          "port16");
    check({7'h00, dma_request}, {7'h00, dma_mode && dma_req},
          "dma req");
    check(8'(volt_class), 8'(exp_volt(volt_code)), "voltage");
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    tick(2);
    check({7'h00, card_reset}, 8'h01, "reset during system reset");
    rst_b = 1'b1;
    tick(2);
    reset_req = 1'b1;
    tick(2);
    check({6'h00, card_reset, req_ready}, 8'h02, "card reset on");
    reset_req = 1'b0;
    tick(2);
    check({6'h00, card_reset, req_ready}, 8'h01, "card reset off");
    for (int k = 0; k < 6; k++) begin
      access(access_kind_t'(k), 1'b1, 2'h3, 1'b1, (k == 1) ? 3 : 0);
      access(access_kind_t'(k), 1'b0, 2'h1, 1'b0, (k == 2) ? 1 : 0);
    end
    for (int i = 0; i < 20; i++) begin
      access(access_kind_t'({$random(seed)} % 6), $random(seed),
             2'({$random(seed)} % 3 + 1), $random(seed), {$random(seed)} % 4);
    end
    for (int i = 0; i < 24; i++) begin
      status_round();
    end
    complete_run();
  end
endmodule // card16_socket_control_tb

`default_nettype wire
